/* File: src/sys_port_pkg.sv */
package sys_port_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_COUNT = 256;

  // ----------------------------------------------------------------
  // timing: figures in ns, cycle counts at the 4 ns clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CS_TO_WAIT_MAX_NS = 126;
  localparam int unsigned WAIT_CYCLES_MAX = CS_TO_WAIT_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned IRQ_IN_MIN_NS = 504;
  localparam int unsigned IRQ_IN_MIN_CYCLES = (IRQ_IN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_LATENCY_NS = 16;
  localparam int unsigned ACCESS_CYCLES = ACCESS_LATENCY_NS / CLK_PERIOD_NS;
  localparam logic [7:0] ACCESS_CYCLES_W = 8'(ACCESS_CYCLES);
  localparam logic [7:0] IRQ_IN_CYCLES_W = 8'(IRQ_IN_MIN_CYCLES);

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_HOLD,
    BUS_DONE
  } bus_state_t;

endpackage : sys_port_pkg

/* File: src/access_timer.sv */
`timescale 1ns/1ns
module access_timer
  import sys_port_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_start,
  input  wire logic [7:0] i_count,
  output logic            o_expired
);
  logic [7:0] count_reg;
  logic       run_reg;

  // expires one cycle after the count reaches zero, then holds until restarted
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_reg <= 8'h00;
      run_reg   <= 1'b0;
      o_expired <= 1'b0;
    end else if (i_start) begin
      count_reg <= i_count;
      run_reg   <= 1'b1;
      o_expired <= 1'b0;
    end else if (run_reg) begin
      if (count_reg == 8'h00) begin
        run_reg   <= 1'b0;
        o_expired <= 1'b1;
      end else begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end
endmodule : access_timer

/* File: src/irq_in_filter.sv */
`timescale 1ns/1ns
module irq_in_filter
  import sys_port_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_level,
  output logic            o_pending
);
  logic [7:0] high_reg;

  // a request counts only after the level has stood for the least active time
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      high_reg  <= 8'h00;
      o_pending <= 1'b0;
    end else if (!i_level) begin
      high_reg  <= 8'h00;
      o_pending <= 1'b0;
    end else if (high_reg >= IRQ_IN_CYCLES_W - 8'h01) begin
      o_pending <= 1'b1;
    end else begin
      high_reg <= high_reg + 8'h01;
    end
  end
endmodule : irq_in_filter

/* File: src/system_processor_bus_port.sv */
`timescale 1ns/1ns
// What this block does
// - 32-bit shared data bus, little-endian, split into in, out and enable
// - 8-bit address picks one of 256 interface words per access
// - accesses are honoured only while select is low and firmware load mode is off
// - read strobe low returns the addressed word on the data bus
// - write strobe low stores the data bus into the addressed word
// - stall output goes low when select goes low outside firmware load mode, inserting wait states
// - busy high tells the processor not to raise its interrupt request
// - interrupt output notifies the processor of firmware events
// - four programming lines used while firmware is loaded; load select is passed to the firmware at all times
// - dma uses active-low request out and active-low grant in
module system_processor_bus_port
(
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  input  wire logic                        i_select_n,
  input  wire logic                        i_read_n,
  input  wire logic                        i_write_n,
  input  wire logic [sys_port_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [sys_port_pkg::DATA_W-1:0] i_data,
  output logic      [sys_port_pkg::DATA_W-1:0] o_data,
  output logic                             o_data_oe,
  output logic                             o_wait_n,
  output logic                             o_busy,
  input  wire logic                        i_more,
  input  wire logic                        i_irq_to_device,
  output logic                             o_irq_to_processor,
  input  wire logic                        i_firmware_load_mode,
  output logic                             o_load_ready,
  input  wire logic                        i_load_done,
  input  wire logic                        i_load_select,
  output logic                             o_dma_request_n,
  input  wire logic                        i_dma_grant_n,
  // firmware side
  input  wire logic                        i_fw_busy,
  input  wire logic                        i_fw_event,
  input  wire logic                        i_fw_dma_want,
  output logic                             o_fw_irq_pending,
  output logic                             o_fw_pio_active,
  output logic                             o_fw_dma_beat,
  output logic                             o_fw_load_strobe,
  output logic                             o_fw_load_target
);
  import sys_port_pkg::*;

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] regs_mem [REG_COUNT];
  bus_state_t        state_reg;
  bus_state_t        state_next;
  logic              timer_start;
  logic              timer_done;
  logic              irq_pending;
  logic              done_reg;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire selected   = !i_select_n;
  wire strobe     = selected && (!i_read_n || !i_write_n);
  wire is_write   = !i_write_n;
  wire load_idle  = !i_firmware_load_mode;
  wire dma_active = !o_dma_request_n && !i_dma_grant_n;

  assign timer_start = (state_reg == BUS_IDLE) && strobe && load_idle;

  access_timer u_timer (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_start   (timer_start),
    .i_count   (ACCESS_CYCLES_W),
    .o_expired (timer_done)
  );

  irq_in_filter u_irq (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_level   (i_irq_to_device),
    .o_pending (irq_pending)
  );

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BUS_IDLE: if (timer_start) state_next = BUS_HOLD;
      BUS_HOLD: if (!selected) state_next = BUS_IDLE;
                else if (timer_done) state_next = BUS_DONE;
      BUS_DONE: if (!selected || (i_read_n && i_write_n)) state_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) state_reg <= BUS_IDLE;
    else state_reg <= state_next;
  end

  // write captured once, at the end of the wait; word kept little-endian as presented
  always_ff @(posedge i_clk) begin
    if (state_reg == BUS_HOLD && timer_done && selected && is_write) begin
      regs_mem[i_addr] <= i_data;
    end
  end

  // ----------------------------------------------------------------
  // pin outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_data    <= DATA_RESET;
      o_data_oe <= 1'b0;
      o_wait_n  <= 1'b1;
    end else begin
      // stall drops with select and rises when the access is ready
      o_wait_n  <= !(selected && load_idle && state_next != BUS_DONE);
      // drive only during a granted read; release as soon as the strobe goes
      o_data_oe <= selected && !i_read_n && i_write_n && load_idle;
      if (state_reg == BUS_HOLD && timer_done && selected && !i_read_n)
        o_data <= regs_mem[i_addr];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_busy             <= 1'b0;
      o_irq_to_processor <= 1'b0;
      o_dma_request_n    <= 1'b1;
      o_load_ready       <= 1'b0;
      o_fw_irq_pending   <= 1'b0;
      o_fw_pio_active    <= 1'b0;
      o_fw_dma_beat      <= 1'b0;
      o_fw_load_strobe   <= 1'b0;
      o_fw_load_target   <= 1'b0;
      done_reg           <= 1'b0;
    end else begin
      o_busy             <= i_fw_busy || i_firmware_load_mode;
      o_irq_to_processor <= i_fw_event && load_idle;
      // request held until the grant arrives for the beat
      o_dma_request_n    <= !(i_fw_dma_want && load_idle && !dma_active);
      o_fw_dma_beat      <= dma_active;
      // the request is reported while busy is low only; a request raised
      // during busy is held back until busy falls, then reported if the level is still high
      o_fw_irq_pending   <= irq_pending && !o_busy;
      o_fw_pio_active    <= i_more;
      // loader: ready while loading and not done, one strobe per done edge
      done_reg           <= i_load_done;
      o_load_ready       <= i_firmware_load_mode && !i_load_done;
      o_fw_load_strobe   <= i_firmware_load_mode && i_load_done && !done_reg;
      o_fw_load_target   <= i_load_select;
    end
  end

endmodule : system_processor_bus_port

/* File: bench/sys_port_chk.sv */
`timescale 1ns/1ns
module sys_port_chk (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_select_n,
  input wire logic i_read_n,
  input wire logic i_write_n,
  input wire logic i_firmware_load_mode,
  input wire logic o_data_oe,
  input wire logic o_wait_n,
  input wire logic i_fw_event,
  input wire logic o_irq_to_processor,
  input wire logic i_fw_dma_want,
  input wire logic i_dma_grant_n,
  input wire logic o_dma_request_n,
  input wire logic o_fw_dma_beat
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_ws; $fell(i_select_n) && !i_firmware_load_mode |=> !o_wait_n; endproperty
  a_ws: assert property (p_ws) else $error("wait missing");
  property p_wl; $fell(o_wait_n) |-> !o_wait_n[*6] ##1 o_wait_n; endproperty
  a_wl: assert property (p_wl) else $error("wait length");
  property p_oe; o_data_oe |-> !$past(i_read_n) && !$past(i_select_n); endproperty
  a_oe: assert property (p_oe) else $error("drive without read");
  property p_wr; !i_write_n && !$past(i_write_n) |-> !o_data_oe; endproperty
  a_wr: assert property (p_wr) else $error("drive during write");
  property p_ld; i_firmware_load_mode && $past(i_firmware_load_mode) && o_wait_n |=> o_wait_n; endproperty
  a_ld: assert property (p_ld) else $error("wait in load mode");
  property p_io;
    o_irq_to_processor == ($past(i_fw_event) && !$past(i_firmware_load_mode));
  endproperty
  a_io: assert property (p_io) else $error("irq out");
  property p_dq;
    $rose(i_fw_dma_want) && i_dma_grant_n && !i_firmware_load_mode |=> !o_dma_request_n;
  endproperty
  a_dq: assert property (p_dq) else $error("dma request");
  property p_dg; !i_dma_grant_n && !o_dma_request_n |=> o_dma_request_n && o_fw_dma_beat; endproperty
  a_dg: assert property (p_dg) else $error("dma grant");
  c_rd: cover property (o_data_oe && o_wait_n);
  c_dma: cover property (o_fw_dma_beat);
  c_irq: cover property (o_irq_to_processor);
endmodule : sys_port_chk
bind system_processor_bus_port sys_port_chk u_chk (.*);

/* File: bench/proc_model.sv */
`timescale 1ns/1ns
module proc_model (
  input  wire logic        i_clk,
  input  wire logic        i_wait_n,
  input  wire logic [31:0] i_bus,
  output logic             o_select_n,
  output logic             o_read_n,
  output logic             o_write_n,
  output logic [7:0]       o_addr,
  output logic [31:0]      o_data
);
  // accesses whose stall never lifted; the bench counts them as mismatches
  int hang_count = 0;
  initial begin
    {o_select_n, o_read_n, o_write_n} = 3'h7;
    o_addr = 8'h00;
    o_data = 32'h0;
  end
  // strobe and select held until stall lifts or 20 polls run out; address and data then show the inverse
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(negedge i_clk);
    o_select_n <= 1'b0;
    o_read_n <= wr;
    o_write_n <= !wr;
    o_addr <= a;
    o_data <= d;
    repeat (3) @(posedge i_clk);
    for (n = 0; n < 20 && i_wait_n !== 1'b1; n++) @(posedge i_clk);
    if (i_wait_n !== 1'b1) hang_count++;
    q = i_bus;
    @(negedge i_clk);
    {o_select_n, o_read_n, o_write_n} <= 3'h7;
    o_addr <= ~a;
    o_data <= ~d;
  endtask : access
endmodule : proc_model

/* File: bench/system_processor_bus_port_test.sv */
`timescale 1ns/1ns
module system_processor_bus_port_test;
  import sys_port_pkg::*;
  logic i_clk, i_reset, i_select_n, i_read_n, i_write_n, o_data_oe, o_wait_n, o_busy, i_more;
  logic i_irq_to_device, o_irq_to_processor, i_firmware_load_mode, o_load_ready, i_load_done;
  logic i_load_select, o_dma_request_n, i_dma_grant_n, i_fw_busy, i_fw_event, i_fw_dma_want;
  logic o_fw_irq_pending, o_fw_pio_active, o_fw_dma_beat, o_fw_load_strobe, o_fw_load_target;
  logic [7:0]  i_addr;
  logic [31:0] i_data, o_data, pm_data, q;
  int fail_count = 0;
  int n_checks = 0;
  system_processor_bus_port dut (.*);
  proc_model u_pm (.i_clk(i_clk), .i_wait_n(o_wait_n), .i_bus(i_data), .o_select_n(i_select_n),
    .o_read_n(i_read_n), .o_write_n(i_write_n), .o_addr(i_addr), .o_data(pm_data));
  assign i_data = o_data_oe ? o_data : pm_data;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic test_done;
    fail_count += u_pm.hang_count;
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic t_rw;
    i_more = 1'b1;
    u_pm.access(1'b1, 8'h00, 32'hA5A5_0001, q);
    chk("pio_on", o_fw_pio_active, 1);
    u_pm.access(1'b1, 8'hFF, 32'h5A5A_F00D, q);
    u_pm.access(1'b0, 8'h00, 32'h0, q);
    chk("rd_lo", q, 32'hA5A5_0001);
    u_pm.access(1'b0, 8'hFF, 32'h0, q);
    chk("rd_hi", q, 32'h5A5A_F00D);
    i_more = 1'b0;
    @(negedge i_clk) chk("pio_off", o_fw_pio_active, 0);
  endtask : t_rw
  task automatic t_load;
    i_firmware_load_mode = 1'b1;
    i_load_select = 1'b1;
    u_pm.access(1'b1, 8'h00, 32'hDEAD_BEEF, q);
    chk("ready", o_load_ready, 1);
    chk("load_busy", o_busy, 1);
    i_load_done = 1'b1;
    @(negedge i_clk) chk("strobe", o_fw_load_strobe, 1);
    chk("ready_off", o_load_ready, 0);
    chk("target", o_fw_load_target, 1);
    @(negedge i_clk) chk("strobe_once", o_fw_load_strobe, 0);
    {i_load_done, i_load_select, i_firmware_load_mode} = 3'h0;
    u_pm.access(1'b0, 8'h00, 32'h0, q);
    chk("refused", q, 32'hA5A5_0001);
  endtask : t_load
  task automatic t_irq;
    @(negedge i_clk) i_fw_event = 1'b1;
    @(negedge i_clk) chk("irq_out", o_irq_to_processor, 1);
    i_fw_event = 1'b0;
    i_fw_busy = 1'b1;
    i_irq_to_device = 1'b1;
    repeat (140) @(negedge i_clk);
    chk("busy", o_busy, 1);
    chk("masked", o_fw_irq_pending, 0);
    i_fw_busy = 1'b0;
    repeat (140) @(negedge i_clk);
    chk("pending", o_fw_irq_pending, 1);
    i_irq_to_device = 1'b0;
  endtask : t_irq
  task automatic t_dma;
    @(negedge i_clk) i_fw_dma_want = 1'b1;
    @(negedge i_clk) chk("dreq", o_dma_request_n, 0);
    i_dma_grant_n = 1'b0;
    @(negedge i_clk) chk("dreq_off", o_dma_request_n, 1);
    chk("beat", o_fw_dma_beat, 1);
    i_dma_grant_n = 1'b1;
    i_fw_dma_want = 1'b0;
    @(negedge i_clk) chk("beat_end", o_fw_dma_beat, 0);
  endtask : t_dma
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    #20000;
    fail_count++;
    test_done();
  end
  initial begin
    {i_reset, i_dma_grant_n} = 2'h3;
    {i_more, i_irq_to_device, i_firmware_load_mode, i_load_done, i_load_select} = 5'h0;
    {i_fw_busy, i_fw_event, i_fw_dma_want} = 3'h0;
    repeat (5) @(negedge i_clk);
    i_reset = 1'b0;
    t_rw();
    t_load();
    t_irq();
    t_dma();
    test_done();
  end
endmodule : system_processor_bus_port_test
